// ===== serial_rx_pkg.sv
package serial_rx_pkg;

  // ----------------------------------------------------------------
  // Clocks and rates
  // ----------------------------------------------------------------
  localparam int  CLK_MHZ  = 100;
  localparam int  CLK_HZ   = CLK_MHZ * 1_000_000;
  localparam int  LOCAL_HZ = 256_000;
  // Rounded divider; 390.625 becomes 391, i.e. 255.75 kHz, inside the trim band.
  localparam int  DIV_CYC  = (CLK_HZ + LOCAL_HZ / 2) / LOCAL_HZ;
  localparam int  DIV_W    = 9;

  // ----------------------------------------------------------------
  // Serial burst format
  // ----------------------------------------------------------------
  localparam longint BIT_NS        = 62_500;
  localparam int     TICKS_PER_BIT = int'((BIT_NS * LOCAL_HZ) / 64'd1_000_000_000);
  localparam int     HALF_BIT      = TICKS_PER_BIT / 2;
  localparam int     DATA_BITS     = 8;
  localparam int     BURST_BITS    = DATA_BITS + 2;
  localparam int     LAST_SAMPLE   = HALF_BIT + (BURST_BITS - 1) * TICKS_PER_BIT;
  localparam int     FRAME_US      = 650;
  localparam int     FRAME_CHK     = (FRAME_US * LOCAL_HZ) / 1_000_000 + 1;
  localparam int     CNT_W         = 8;
  localparam int     STREAMS       = 3;

  // ----------------------------------------------------------------
  // Indicator timing, in local ticks
  // ----------------------------------------------------------------
  localparam int  ACT_MS      = 2;
  localparam int  ACT_TICKS   = ACT_MS * LOCAL_HZ / 1000;
  localparam int  ACT_W       = 10;
  localparam int  FLASH_MS    = 20;
  localparam int  FLASH_TICKS = FLASH_MS * LOCAL_HZ / 1000;
  localparam int  FLASH_W     = 13;

  // ----------------------------------------------------------------
  // Host transfer timing, in ref_clk cycles
  // ----------------------------------------------------------------
  localparam int  MS_US      = 1000;
  localparam int  SLOT_US    = 60;
  localparam int  STROBE_US  = 10;
  localparam int  MS_CYC     = MS_US * CLK_MHZ;
  localparam int  SLOT_CYC   = SLOT_US * CLK_MHZ;
  localparam int  STROBE_CYC = STROBE_US * CLK_MHZ;
  localparam int  MS_W       = 17;
  localparam int  SLOT_W     = 13;
  localparam int  LAST_SLOT  = STREAMS - 1;

  // ----------------------------------------------------------------
  // Word layout: {stream, frame_ok, parity_ok, data}
  // ----------------------------------------------------------------
  localparam int  W_PAR   = 8;
  localparam int  W_FRM   = 9;
  localparam int  REC_W   = 10;
  localparam int  FIFO_W  = 12;
  localparam int  FIFO_D  = 8;

  // Synchronised pin vector positions; serial lines sit in bits 2:0.
  localparam int  P_SHOW  = 3;
  localparam int  P_FRZ   = 4;
  localparam int  P_START = 5;
  localparam int  PIN_W   = 6;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_WAIT_HI} rx_phase_t;

endpackage

// ===== word_fifo.sv
`timescale 1ns/100ps

module word_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_t;

  fifo_t        s_r;
  fifo_t        s_nxt;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign in_ready  = (s_r.cnt != (AW + 1)'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    if (flush) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[s_r.wp] <= in_data;
    end
  end

endmodule

// ===== serial_rx.sv
// Contract
// - Burst is a zero start bit, eight data bits LSB first, one parity bit.
// - Every bit cell lasts 62.5 us, a 16 kHz bit rate.
// - Parity is one for an even count of ones; received bursts are checked.
// - Stream one carries channel one seeing, stream two channel two seeing.
// - Stream three cycles sync, wander one, wander two, range and orientation.
// - A 256 kHz local tick times all three deserialisers.
// - Per-stream activity light stays dark while no bursts arrive.
// - Shared parity fault light flashes briefly on any stream's parity mismatch.
// - A burst wider than 650 us flags a framing or overrun fault.
// - Receiver idles after reset until start; start later restarts reception.
// - Display select chooses seeing or wander for the shared lights.
// - Freeze holds the shown seeing or wander values until run returns.
// - Twelve parallel host data lines plus one strobe line are driven.
// - Each millisecond, three 60 us slots with a 10 us strobe each.
// - First slot carries stream one byte on host data, LSB on line one.
// - Line nine high unless parity fault, line ten high unless framing fault.
// - Lines eleven and twelve: 11 stream one, 01 stream two, 10 stream three.
`timescale 1ns/100ps

module serial_rx #(
  parameter int     MS_CYC    = serial_rx_pkg::MS_CYC,
  parameter int     SLOT_CYC  = serial_rx_pkg::SLOT_CYC,
  parameter logic [7:0] SYNC_BYTE = 8'h00
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Serial lines and panel switches
  input  wire logic [2:0] ser_in,
  input  wire logic       start_btn,
  input  wire logic       show_wander,
  input  wire logic       freeze,
  // Panel lights
  output logic            clock_light,
  output logic [2:0]      data_rcvd,
  output logic            parity_err_light,
  output logic            frame_err_light,
  output logic [7:0]      disp_ch1,
  output logic [7:0]      disp_ch2,
  output logic [7:0]      range_orient,
  // Host bus
  output logic [7:0]      host_data,
  output logic            host_parity_ok,
  output logic            host_frame_ok,
  output logic            host_stream_id_a,
  output logic            host_stream_id_b,
  output logic            host_slot_strobe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [serial_rx_pkg::PIN_W-1:0]            sy1;
    logic [serial_rx_pkg::PIN_W-1:0]            sy2;
    logic                                       st_prev;
    logic                                       run;
    logic                                       flush;
    logic [serial_rx_pkg::DIV_W-1:0]            div;
    logic                                       tick;
    logic                                       clk_lt;
    serial_rx_pkg::rx_phase_t [2:0]             phase;
    logic [2:0][serial_rx_pkg::CNT_W-1:0]       cnt;
    logic [2:0][8:0]                            shift;
    logic [2:0]                                 pend;
    logic [2:0][serial_rx_pkg::REC_W-1:0]       pword;
    logic [2:0][serial_rx_pkg::ACT_W-1:0]       act;
    logic [2:0]                                 rcvd;
    logic [serial_rx_pkg::FLASH_W-1:0]          par_fl;
    logic [serial_rx_pkg::FLASH_W-1:0]          frm_fl;
    logic                                       par_lt;
    logic                                       frm_lt;
    logic [2:0][serial_rx_pkg::REC_W-1:0]       latest;
    logic [7:0]                                 see1;
    logic [7:0]                                 see2;
    logic [7:0]                                 wnd1;
    logic [7:0]                                 wnd2;
    logic [7:0]                                 rng;
    logic [1:0]                                 pos;
    logic [7:0]                                 d1;
    logic [7:0]                                 d2;
    logic [serial_rx_pkg::MS_W-1:0]             ms_cnt;
    logic [serial_rx_pkg::SLOT_W-1:0]           sl_cnt;
    logic [1:0]                                 sl_idx;
    logic                                       win;
    logic [serial_rx_pkg::FIFO_W-1:0]           bus;
    logic                                       strobe;
  } st_t;

  st_t                               s_r;
  st_t                               s_nxt;
  logic [1:0]                        push_idx;
  logic                              f_in_valid;
  logic                              f_in_ready;
  logic [serial_rx_pkg::FIFO_W-1:0]  f_in_data;
  logic                              f_out_valid;
  logic                              f_out_ready;
  logic [serial_rx_pkg::FIFO_W-1:0]  f_out_data;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Received parity must be one exactly when the data has an even count of ones.
  function automatic logic par_good(input logic [8:0] sh);
    par_good = (sh[8] == ~^sh[7:0]);
  endfunction

  // Returns {line twelve, line eleven} for a slot.
  function automatic logic [1:0] id_code(input logic [1:0] idx);
    unique case (idx)
      2'h0:    id_code = 2'b11;
      2'h1:    id_code = 2'b10;
      default: id_code = 2'b01;
    endcase
  endfunction

  function automatic logic [1:0] pick(input logic [2:0] p);
    pick = p[0] ? 2'h0 : (p[1] ? 2'h1 : 2'h2);
  endfunction

  // ----------------------------------------------------------------
  // FIFO between deserialisers and host side
  // ----------------------------------------------------------------
  // The drain stalls in the host window and on the cycle that loads its first word, so slot
  // words stay steady; a full FIFO holds words in the per-stream pending registers.
  assign push_idx    = pick(s_r.pend);
  assign f_in_valid  = |s_r.pend;
  assign f_in_data   = {push_idx, s_r.pword[push_idx]};
  assign f_out_ready = !s_r.win && (s_r.ms_cnt != '0);

  word_fifo #(
    .W (serial_rx_pkg::FIFO_W),
    .D (serial_rx_pkg::FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (s_r.flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                                   line;
    logic [1:0]                             idx;
    logic [serial_rx_pkg::REC_W-1:0]        rec;
    line  = 1'b1;
    idx   = '0;
    rec   = '0;
    s_nxt = s_r;
    s_nxt.sy1     = {start_btn, freeze, show_wander, ser_in};
    s_nxt.sy2     = s_r.sy1;
    s_nxt.st_prev = s_r.sy2[serial_rx_pkg::P_START];
    s_nxt.flush   = 1'b0;
    s_nxt.tick    = 1'b0;
    if (s_r.div == serial_rx_pkg::DIV_W'(serial_rx_pkg::DIV_CYC - 1)) begin
      s_nxt.div  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 1'b1;
    end
    if (s_r.tick) begin
      s_nxt.clk_lt = !s_r.clk_lt;
    end
    if (f_in_valid && f_in_ready) begin
      s_nxt.pend[push_idx] = 1'b0;
    end
    if (s_r.run && s_r.tick) begin
      if (s_r.par_fl != '0) begin
        s_nxt.par_fl = s_r.par_fl - 1'b1;
      end
      if (s_r.frm_fl != '0) begin
        s_nxt.frm_fl = s_r.frm_fl - 1'b1;
      end
      for (int i = 0; i < serial_rx_pkg::STREAMS; i++) begin
        line = s_r.sy2[i];
        if (s_r.act[i] != '0) begin
          s_nxt.act[i] = s_r.act[i] - 1'b1;
        end
        s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
        unique case (s_r.phase[i])
          serial_rx_pkg::RX_IDLE: begin
            s_nxt.cnt[i] = '0;
            if (!line) begin
              s_nxt.phase[i] = serial_rx_pkg::RX_START;
            end
          end
          serial_rx_pkg::RX_START: begin
            if (s_r.cnt[i] == serial_rx_pkg::CNT_W'(serial_rx_pkg::HALF_BIT)) begin
              // A start bit that is high at mid-cell was a glitch.
              s_nxt.phase[i] = line ? serial_rx_pkg::RX_IDLE : serial_rx_pkg::RX_BITS;
            end
          end
          serial_rx_pkg::RX_BITS: begin
            if (s_r.cnt[i][3:0] == 4'(serial_rx_pkg::HALF_BIT) &&
                s_r.cnt[i] <= serial_rx_pkg::CNT_W'(serial_rx_pkg::LAST_SAMPLE)) begin
              s_nxt.shift[i] = {line, s_r.shift[i][8:1]};
            end
            if (s_r.cnt[i] == serial_rx_pkg::CNT_W'(serial_rx_pkg::FRAME_CHK)) begin
              // A line still low here means the burst ran past its limit.
              rec = {line && !s_nxt.pend[i], par_good(s_r.shift[i]), s_r.shift[i][7:0]};
              s_nxt.pword[i] = rec;
              s_nxt.pend[i]  = 1'b1;
              s_nxt.act[i]   = serial_rx_pkg::ACT_W'(serial_rx_pkg::ACT_TICKS);
              if (!rec[serial_rx_pkg::W_PAR]) begin
                s_nxt.par_fl = serial_rx_pkg::FLASH_W'(serial_rx_pkg::FLASH_TICKS);
              end
              if (!rec[serial_rx_pkg::W_FRM]) begin
                s_nxt.frm_fl = serial_rx_pkg::FLASH_W'(serial_rx_pkg::FLASH_TICKS);
              end
              s_nxt.phase[i] = line ? serial_rx_pkg::RX_IDLE : serial_rx_pkg::RX_WAIT_HI;
            end
          end
          serial_rx_pkg::RX_WAIT_HI: begin
            if (line) begin
              s_nxt.phase[i] = serial_rx_pkg::RX_IDLE;
            end
          end
        endcase
      end
    end
    for (int i = 0; i < serial_rx_pkg::STREAMS; i++) begin
      s_nxt.rcvd[i] = (s_nxt.act[i] != '0);
    end
    s_nxt.par_lt = (s_nxt.par_fl != '0);
    s_nxt.frm_lt = (s_nxt.frm_fl != '0);
    // Drain one word into the per-stream display and host stores.
    if (f_out_valid && f_out_ready) begin
      idx = f_out_data[11:10];
      s_nxt.latest[idx] = f_out_data[9:0];
      if (idx == 2'h2) begin
        s_nxt.pos = s_r.pos + 1'b1;
        if (f_out_data[7:0] == SYNC_BYTE) begin
          s_nxt.pos = 2'h1;
        end else if (s_r.pos == 2'h3) begin
          s_nxt.rng = f_out_data[7:0];
        end
      end
      if (!s_r.sy2[serial_rx_pkg::P_FRZ]) begin
        if (idx == 2'h0) begin
          s_nxt.see1 = f_out_data[7:0];
        end else if (idx == 2'h1) begin
          s_nxt.see2 = f_out_data[7:0];
        end else if (f_out_data[7:0] != SYNC_BYTE && s_r.pos == 2'h1) begin
          s_nxt.wnd1 = f_out_data[7:0];
        end else if (f_out_data[7:0] != SYNC_BYTE && s_r.pos == 2'h2) begin
          s_nxt.wnd2 = f_out_data[7:0];
        end
      end
    end
    s_nxt.d1 = s_r.sy2[serial_rx_pkg::P_SHOW] ? s_r.wnd1 : s_r.see1;
    s_nxt.d2 = s_r.sy2[serial_rx_pkg::P_SHOW] ? s_r.wnd2 : s_r.see2;
    // Host slots: a window of three slots opens at the top of each millisecond.
    if (s_r.run) begin
      s_nxt.ms_cnt = (s_r.ms_cnt == serial_rx_pkg::MS_W'(MS_CYC - 1)) ? '0 : s_r.ms_cnt + 1'b1;
      if (s_r.ms_cnt == '0) begin
        s_nxt.win    = 1'b1;
        s_nxt.sl_idx = '0;
        s_nxt.sl_cnt = '0;
        s_nxt.bus    = {id_code(2'h0), s_r.latest[0]};
        s_nxt.strobe = 1'b1;
      end else if (s_r.win) begin
        s_nxt.sl_cnt = s_r.sl_cnt + 1'b1;
        if (s_r.sl_cnt == serial_rx_pkg::SLOT_W'(serial_rx_pkg::STROBE_CYC - 1)) begin
          s_nxt.strobe = 1'b0;
        end
        if (s_r.sl_cnt == serial_rx_pkg::SLOT_W'(SLOT_CYC - 1)) begin
          s_nxt.sl_cnt = '0;
          if (s_r.sl_idx == 2'(serial_rx_pkg::LAST_SLOT)) begin
            s_nxt.win = 1'b0;
          end else begin
            s_nxt.sl_idx = s_r.sl_idx + 1'b1;
            s_nxt.bus    = {id_code(s_r.sl_idx + 1'b1), s_r.latest[s_r.sl_idx + 1'b1]};
            s_nxt.strobe = 1'b1;
          end
        end
      end
    end
    // Start restarts everything behind the synchronisers and the divider, except the clock light.
    if (s_r.sy2[serial_rx_pkg::P_START] && !s_r.st_prev) begin
      s_nxt         = '0;
      s_nxt.sy1     = {start_btn, freeze, show_wander, ser_in};
      s_nxt.sy2     = s_r.sy1;
      s_nxt.st_prev = 1'b1;
      s_nxt.div     = s_r.div;
      s_nxt.clk_lt  = s_r.clk_lt;
      s_nxt.run     = 1'b1;
      s_nxt.flush   = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign clock_light      = s_r.clk_lt;
  assign data_rcvd        = s_r.rcvd;
  assign parity_err_light = s_r.par_lt;
  assign frame_err_light  = s_r.frm_lt;
  assign disp_ch1         = s_r.d1;
  assign disp_ch2         = s_r.d2;
  assign range_orient     = s_r.rng;
  assign host_data        = s_r.bus[7:0];
  assign host_parity_ok   = s_r.bus[serial_rx_pkg::W_PAR];
  assign host_frame_ok    = s_r.bus[serial_rx_pkg::W_FRM];
  assign host_stream_id_a = s_r.bus[10];
  assign host_stream_id_b = s_r.bus[11];
  assign host_slot_strobe = s_r.strobe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.tick |=> !s_r.tick [*8]) else $error("local tick too frequent");
  strobe_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_slot_strobe |-> s_r.win && s_r.sl_cnt < serial_rx_pkg::SLOT_W'(serial_rx_pkg::STROBE_CYC))
    else $error("strobe outside its first 10 us");
  window_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.win |-> s_r.sl_idx <= 2'(serial_rx_pkg::LAST_SLOT) &&
      s_r.ms_cnt <= serial_rx_pkg::MS_W'(3 * SLOT_CYC)) else $error("host window too long");
  slot_id_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.win |-> {host_stream_id_b, host_stream_id_a} == id_code(s_r.sl_idx))
    else $error("wrong stream id on host lines");
  slot_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.win && s_r.sl_idx == 2'h0) |-> host_data == s_r.latest[0][7:0])
    else $error("slot one data mismatch");
  slot_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.win |-> {host_frame_ok, host_parity_ok} == s_r.latest[s_r.sl_idx][9:8])
    else $error("slot fault lines mismatch");
  idle_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_r.run |-> !host_slot_strobe && data_rcvd == 3'h0 && !f_in_valid)
    else $error("activity before start");
  parity_flash_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.run && s_r.tick && s_r.phase[1] == serial_rx_pkg::RX_BITS &&
     s_r.cnt[1] == serial_rx_pkg::CNT_W'(serial_rx_pkg::FRAME_CHK) && !par_good(s_r.shift[1]) &&
     !(s_r.sy2[serial_rx_pkg::P_START] && !s_r.st_prev))
    |=> parity_err_light && s_r.pend[1] && !s_r.pword[1][serial_rx_pkg::W_PAR])
    else $error("parity fault not flagged");
  frame_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.run && s_r.tick && s_r.phase[2] == serial_rx_pkg::RX_BITS && !s_r.sy2[2] &&
     s_r.cnt[2] == serial_rx_pkg::CNT_W'(serial_rx_pkg::FRAME_CHK) &&
     !(s_r.sy2[serial_rx_pkg::P_START] && !s_r.st_prev))
    |=> frame_err_light && !s_r.pword[2][serial_rx_pkg::W_FRM]) else $error("long burst not flagged");
  display_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(s_r.sy2[serial_rx_pkg::P_START] && !s_r.st_prev) |=>
      disp_ch1 == ($past(s_r.sy2[serial_rx_pkg::P_SHOW]) ? $past(s_r.wnd1) : $past(s_r.see1)))
    else $error("display select wrong");
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.sy2[serial_rx_pkg::P_FRZ] && $past(s_r.sy2[serial_rx_pkg::P_FRZ]) &&
     $stable(s_r.sy2[serial_rx_pkg::P_SHOW]) && s_r.run && $past(s_r.run) &&
     !(s_r.sy2[serial_rx_pkg::P_START] && !s_r.st_prev)) |=> $stable(disp_ch2))
    else $error("display changed while frozen");
endmodule

// ===== ser_tx_model.sv
`timescale 1ns/100ps

module ser_tx_model #(
  parameter int BIT_CYC = 6250
) (
  // Clock and trigger
  input  wire logic       ref_clk,
  input  wire logic       go,
  // Burst content and faults
  input  wire logic [7:0] tx_byte,
  input  wire logic       bad_par,
  input  wire logic       long_low,
  // Serial line
  output logic            line
);
  int i;
  initial line = 1'b1;
  always @(posedge ref_clk) begin
    if (go) begin
      line <= 1'b0;
      repeat (BIT_CYC) @(posedge ref_clk);
      for (i = 0; i < 8; i++) begin
        line <= tx_byte[i];
        repeat (BIT_CYC) @(posedge ref_clk);
      end
      line <= ~^tx_byte ^ bad_par;
      repeat (BIT_CYC) @(posedge ref_clk);
      // A held-low tail stands in for a stretched tape burst.
      if (long_low) begin
        line <= 1'b0;
        repeat (2 * BIT_CYC) @(posedge ref_clk);
      end
      line <= 1'b1;
    end
  end
endmodule

// ===== tb_serial_rx.sv
`timescale 1ns/100ps

module tb_serial_rx;
  logic        ref_clk, rst_n, start_btn, show_wander, freeze, go;
  logic [2:0]  data_rcvd, bad_par, long_low;
  wire  [2:0]  ser_in;
  logic [23:0] tx_bytes;
  logic        clock_light, parity_err_light, frame_err_light;
  logic [7:0]  disp_ch1, disp_ch2, range_orient, host_data;
  logic        host_parity_ok, host_frame_ok, host_stream_id_a, host_stream_id_b, host_slot_strobe;
  int          error_cnt, samples_checked, cyc;

  serial_rx #(.MS_CYC(12000), .SLOT_CYC(3000)) u_serial_rx (
    .ref_clk(ref_clk), .rst_n(rst_n), .ser_in(ser_in), .start_btn(start_btn),
    .show_wander(show_wander), .freeze(freeze), .clock_light(clock_light),
    .data_rcvd(data_rcvd), .parity_err_light(parity_err_light), .frame_err_light(frame_err_light),
    .disp_ch1(disp_ch1), .disp_ch2(disp_ch2), .range_orient(range_orient), .host_data(host_data),
    .host_parity_ok(host_parity_ok), .host_frame_ok(host_frame_ok), .host_stream_id_a(host_stream_id_a),
    .host_stream_id_b(host_stream_id_b), .host_slot_strobe(host_slot_strobe));

  ser_tx_model u_ser_tx_model[2:0] (.ref_clk(ref_clk), .go(go), .tx_byte(tx_bytes),
    .bad_par(bad_par), .long_low(long_low), .line(ser_in));

  // ------------------------------------------------------------
  // Clock, timeout and checking helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [11:0] word();
    return {host_stream_id_b, host_stream_id_a, host_frame_ok, host_parity_ok, host_data};
  endfunction

  // Counts cycles until the strobe next rises; h returns the high part.
  task automatic next_rise(output int h, output int n);
    h = 0;
    n = 0;
    while (host_slot_strobe === 1'b1 && n < 30000) begin
      @(posedge ref_clk); #1; n++; h++;
    end
    while (host_slot_strobe !== 1'b1 && n < 30000) begin
      @(posedge ref_clk); #1; n++;
    end
  endtask

  task automatic chk_slot(input logic [11:0] exp, input logic spaced);
    int h, n;
    chk("host_word", exp, word());
    next_rise(h, n);
    chk("strobe_width", 12'd1000, h[11:0]);
    if (spaced) chk("slot_period", 12'd3000, n[11:0]);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic idle_before_start();
    int i, seen;
    seen = 0;
    for (i = 0; i < 1000; i++) begin
      @(posedge ref_clk); #1;
      if (host_slot_strobe !== 1'b0) seen++;
    end
    chk("strobe_idle", 12'd0, seen[11:0]);
    chk("word_idle", 12'h000, word());
    chk("activity_idle", 12'h000, {9'h000, data_rcvd});
  endtask

  task automatic three_bursts();
    int h, n, k;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (70000) @(posedge ref_clk);
    #1;
    chk("activity", 12'h007, {9'h000, data_rcvd});
    chk("parity_light", 12'h001, {11'h000, parity_err_light});
    chk("frame_light", 12'h001, {11'h000, frame_err_light});
    chk("seeing1", 12'h0A5, {4'h0, disp_ch1});
    chk("seeing2", 12'h03C, {4'h0, disp_ch2});
    for (k = 0; k < 10 && word() !== 12'hFA5; k++) next_rise(h, n);
    chk_slot(12'hFA5, 1'b1);
    chk_slot(12'hA3C, 1'b1);
    chk_slot(12'h581, 1'b0);
  endtask

  // Clock light rate, range store, then display select over frozen values.
  task automatic select_and_lights();
    int   i, flips;
    logic prev;
    flips = 0;
    prev  = clock_light;
    for (i = 0; i < 2 * serial_rx_pkg::DIV_CYC; i++) begin
      @(posedge ref_clk); #1;
      if (clock_light !== prev) flips++;
      prev = clock_light;
    end
    chk("clock_flips", 12'd2, flips[11:0]);
    chk("range_orient", 12'h000, {4'h0, range_orient});
    @(posedge ref_clk);
    freeze      <= 1'b1;
    show_wander <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("wander1", 12'h000, {4'h0, disp_ch1});
    chk("wander2", 12'h000, {4'h0, disp_ch2});
    @(posedge ref_clk);
    show_wander <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("held1", 12'h0A5, {4'h0, disp_ch1});
    chk("held2", 12'h03C, {4'h0, disp_ch2});
  endtask

  initial begin
    {rst_n, start_btn, show_wander, freeze, go} = 5'b00000;
    tx_bytes = 24'h81_3CA5;
    bad_par = 3'b010;
    long_low = 3'b100;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle_before_start();
    @(posedge ref_clk);
    start_btn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    start_btn <= 1'b0;
    three_bursts();
    select_and_lights();
    print_verdict();
  end
endmodule
